/* File: rtl/dma_accum.sv */
// Contract
// (R1) Selections 55 to 57 show a terminal on/off pattern in the third monitor slot.
// (R2) Segment lit while its terminal is on; middle segment always lit. The code darks it for 56 and 57 without their option.
// (R3) Selections 56 and 57 accepted without option; then all segments dark.
// (R4) Selection 55: built-in inputs on upper segments, outputs on lower segments.
// (R5) Selection 56 lights first digit point; 57 lights second digit point.
// (R6) Selection 25 accumulates output power, total refreshed once per hour.
// (R7) Energy shown at 0.01, 0.1 or 1 kWh resolution by value band.
// (R8) Energy display limited to four digits, point chosen by band.
// (R9) Energy value shifted right by digit-shift decimal digits, display and comms. Comms shifts only three digits when the shift is 4.
// (R10) Over maximum: clamp when shift 0 to 4, wrap to zero when 9999.
// (R11) Writing zero to energy clear resets the energy total.
// (R12) Energy clear reads back 9999 or 10, never zero.
// (R13) Energized hours increment every hour while powered.
// (R14) Run hours count only while running, held while stopped.
// (R15) Hour counters wrap past 65535, each wrap bumps its own tally.
// (R16) Zero to run clear resets run hours; energized hours cannot clear.
// (R17) Run hour credited only after a full continuous hour of running.
// (R18) Run clear always reads 9999; writing 9999 changes nothing.
// (R19) Truncation: 9999 off, 0 to integer, 1 two decimals to one.
// (R20) Truncation never alters selections 20, 23, 25 and 51.
// (R21) Hour counters shown in thousands of hours, up to 65.53, then restart.
// (R22) Free-running prescaler gives one-cycle hourly tick driving all accumulation.
// (R23) Energy accumulator holds 9999.99 kWh at 0.01 kWh resolution.
//
// Our own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "dma_defs.svh"

module dma_accum #(
  parameter logic [63:0] HOUR_CYCLES = `DMA_HOUR_CYCLES
) (
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic [31:0]            wb_dat_out,
  output logic                   wb_ack_out,
  input  wire logic [15:0]       power_in,
  input  wire logic              running_in,
  input  wire dma_pkg::dma_term_s term_in,
  input  wire dma_pkg::dma_mon_s  mon_in,
  output var dma_pkg::dma_panel_s panel_out
);

  function automatic logic [19:0] div_pow10(input logic [19:0] v, input logic [2:0] n);
    case (n)
      3'd0:    div_pow10 = v;
      3'd1:    div_pow10 = v / 20'd10;
      3'd2:    div_pow10 = v / 20'd100;
      3'd3:    div_pow10 = v / 20'd1000;
      3'd4:    div_pow10 = v / 20'd10000;
      default: div_pow10 = v / 20'd100000;
    endcase
  endfunction

  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    byte_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [16:0] low17(input logic [19:0] v);
    // Panel value field is 17 bits; every caller keeps its value inside it
    low17 = v[16:0];
  endfunction

  // Time base
  logic [63:0] presc_q, presc_d;
  logic        tick_q, tick_d;

  always_comb begin
    presc_d = presc_q + 64'h0000_0000_0000_0001;
    tick_d  = 1'b0;
    if (presc_q >= HOUR_CYCLES - 64'h0000_0000_0000_0001) begin // [R22]
      presc_d = 64'h0000_0000_0000_0000;
      tick_d  = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      presc_q <= 64'h0000_0000_0000_0000;
      tick_q  <= 1'b0;
    end else begin
      presc_q <= presc_d;
      tick_q  <= tick_d;
    end
  end

  // Bus slave
  logic        req;
  logic        wr_fire;
  logic        ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [6:0]  mon_sel_q, mon_sel_d;
  logic [15:0] shift_q, shift_d;
  logic [15:0] trunc_q, trunc_d;
  logic [15:0] eclr_rd_q, eclr_rd_d;
  logic [15:0] wr_val;
  logic        energy_clr;
  logic        run_clr;

  // Slave answers one cycle after the request; writes land at the acknowledged edge
  assign req     = wb_cyc_in & wb_stb_in;
  assign wr_fire = req & wb_we_in & ack_q;

  logic [19:0] energy_q, energy_d;
  logic [15:0] ehours_q, ehours_d;
  logic [15:0] rhours_q, rhours_d;
  logic [15:0] ewrap_q, ewrap_d;
  logic [15:0] rwrap_q, rwrap_d;
  logic        run_whole_q, run_whole_d;
  logic [19:0] energy_comm;

  always_comb begin
    wr_val     = byte_merge(16'h0000, wb_dat_in, wb_sel_in);
    ack_d      = req & ~ack_q;
    mon_sel_d  = mon_sel_q;
    shift_d    = shift_q;
    trunc_d    = trunc_q;
    eclr_rd_d  = eclr_rd_q;
    energy_clr = 1'b0;
    run_clr    = 1'b0;
    if (wr_fire) begin
      case (wb_adr_in)
        `DMA_OFS_MON_SEL:    if (wb_sel_in[0]) mon_sel_d = wb_dat_in[6:0];
        `DMA_OFS_DIG_SHIFT:
          if (wr_val <= `DMA_SHIFT_MAX || wr_val == `DMA_VAL_NONE) shift_d = wr_val;
        `DMA_OFS_TRUNC_SEL:
          if (wr_val <= `DMA_VAL_ONE || wr_val == `DMA_VAL_NONE) trunc_d = wr_val;
        `DMA_OFS_ENERGY_CLR: begin
          if (wr_val == `DMA_VAL_ZERO) energy_clr = 1'b1; // [R11]
          else if (wr_val == `DMA_VAL_TEN || wr_val == `DMA_VAL_NONE) eclr_rd_d = wr_val; // [R12]
        end
        `DMA_OFS_RUN_CLR:    run_clr = (wr_val == `DMA_VAL_ZERO); // [R16] [R18]
        default:             ;
      endcase
    end
    dat_d = 32'h0000_0000;
    if (req & ~wb_we_in & ~ack_q) begin
      case (wb_adr_in)
        `DMA_OFS_MON_SEL:     dat_d = {25'h000_0000, mon_sel_q};
        `DMA_OFS_DIG_SHIFT:   dat_d = {16'h0000, shift_q};
        `DMA_OFS_TRUNC_SEL:   dat_d = {16'h0000, trunc_q};
        `DMA_OFS_ENERGY_CLR:  dat_d = {16'h0000, eclr_rd_q}; // [R12]
        `DMA_OFS_RUN_CLR:     dat_d = {16'h0000, `DMA_VAL_NONE}; // [R18]
        `DMA_OFS_ENERGY_COMM: dat_d = {12'h000, energy_comm}; // [R9]
        `DMA_OFS_ENERGIZED_H: dat_d = {16'h0000, ehours_q};
        `DMA_OFS_RUN_H:       dat_d = {16'h0000, rhours_q};
        `DMA_OFS_ENERGIZED_W: dat_d = {16'h0000, ewrap_q}; // [R15]
        `DMA_OFS_RUN_W:       dat_d = {16'h0000, rwrap_q}; // [R15]
        `DMA_OFS_ENERGY_RAW:  dat_d = {12'h000, energy_q};
        default:              dat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_q     <= 1'b0;
      dat_q     <= 32'h0000_0000;
      mon_sel_q <= `DMA_MON_SEL_RST;
      shift_q   <= `DMA_VAL_NONE;
      trunc_q   <= `DMA_VAL_NONE;
      eclr_rd_q <= `DMA_VAL_NONE;
    end else begin
      ack_q     <= ack_d;
      dat_q     <= dat_d;
      mon_sel_q <= mon_sel_d;
      shift_q   <= shift_d;
      trunc_q   <= trunc_d;
      eclr_rd_q <= eclr_rd_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = dat_q;

  // Accumulators
  logic [20:0] energy_sum;
  logic [2:0]  shift_n;

  assign shift_n     = (shift_q == `DMA_VAL_NONE) ? 3'd0 : shift_q[2:0];
  // Communication value is whole kWh after the digit shift; shift 4 divides by 100000, the same as shift 3
  assign energy_comm = div_pow10(energy_q, shift_n + 3'd2); // [R9]

  always_comb begin
    energy_sum  = {1'b0, energy_q} + {5'h00, power_in};
    energy_d    = energy_q;
    ehours_d    = ehours_q;
    ewrap_d     = ewrap_q;
    rhours_d    = rhours_q;
    rwrap_d     = rwrap_q;
    run_whole_d = run_whole_q & running_in; // [R17]
    if (tick_q) begin
      if (energy_sum > {1'b0, `DMA_ENERGY_MAX}) begin // [R23]
        energy_d = (shift_q == `DMA_VAL_NONE) ? 20'h0_0000 : `DMA_ENERGY_MAX; // [R10]
      end else begin
        energy_d = energy_sum[19:0]; // [R6]
      end
      ehours_d = ehours_q + 16'h0001; // [R13]
      if (ehours_q == 16'hFFFF) ewrap_d = ewrap_q + 16'h0001; // [R15]
      if (running_in && run_whole_q) begin // [R14] [R17]
        rhours_d = rhours_q + 16'h0001;
        if (rhours_q == 16'hFFFF) rwrap_d = rwrap_q + 16'h0001; // [R15]
      end
      run_whole_d = running_in;
    end
    // Clear wins over a same-cycle hourly update, as software asked for zero
    if (energy_clr) energy_d = 20'h0_0000; // [R11]
    if (run_clr) begin
      rhours_d    = 16'h0000; // [R16]
      run_whole_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      energy_q    <= 20'h0_0000;
      ehours_q    <= 16'h0000;
      rhours_q    <= 16'h0000;
      ewrap_q     <= 16'h0000;
      rwrap_q     <= 16'h0000;
      run_whole_q <= 1'b0;
    end else begin
      energy_q    <= energy_d;
      ehours_q    <= ehours_d;
      rhours_q    <= rhours_d;
      ewrap_q     <= ewrap_d;
      rwrap_q     <= rwrap_d;
      run_whole_q <= run_whole_d;
    end
  end

  // Panel
  dma_pkg::dma_panel_s panel_q, panel_d;
  logic [19:0]         e_shift;
  logic [23:0]         pat;

  always_comb begin
    e_shift = div_pow10(energy_q, shift_n); // [R9]
    panel_d = '0;
    pat     = 24'h00_0000;
    case (mon_sel_q)
      `DMA_SEL_UNIT_IO, `DMA_SEL_OPT_IN, `DMA_SEL_OPT_OUT: begin
        panel_d.terminal_mode = 1'b1; // [R1]
        if (mon_sel_q == `DMA_SEL_UNIT_IO) begin
          for (int i = 0; i < 4; i++) begin
            // Upper a,b,f carry inputs; lower c,d,e carry outputs
            pat[i*6 +: 6] = {term_in.unit_in[i*3 +: 3], term_in.unit_out[i*3 +: 3]}; // [R4]
          end
        end else if (mon_sel_q == `DMA_SEL_OPT_IN) begin
          pat          = term_in.opt_in_fitted ? term_in.opt_in : 24'h00_0000; // [R3]
          panel_d.dp[0] = 1'b1; // [R5]
        end else begin
          pat          = term_in.opt_out_fitted ? term_in.opt_out : 24'h00_0000; // [R3]
          panel_d.dp[1] = 1'b1; // [R5]
        end
        for (int i = 0; i < 4; i++) begin
          // Segment order {g,f,e,d,c,b,a}; middle g dark only with missing option
          panel_d.seg[i] = {~(mon_sel_q != `DMA_SEL_UNIT_IO &&
                              !(mon_sel_q == `DMA_SEL_OPT_IN ? term_in.opt_in_fitted : term_in.opt_out_fitted)),
                            pat[i*6+5], pat[i*6+2], pat[i*6+1], pat[i*6+0],
                            pat[i*6+4], pat[i*6+3]}; // [R2] [R3]
        end
      end
      `DMA_SEL_ENERGY: begin
        if (e_shift < `DMA_DISP_2DEC_LIM) begin // [R7] [R8]
          panel_d.value  = e_shift[16:0];
          panel_d.dp_pos = 2'd2;
        end else if (e_shift < `DMA_DISP_1DEC_LIM) begin
          panel_d.value  = low17(div_pow10(e_shift, 3'd1));
          panel_d.dp_pos = 2'd1;
        end else begin
          panel_d.value  = low17(div_pow10(e_shift, 3'd2));
          panel_d.dp_pos = 2'd0;
        end
      end
      `DMA_SEL_ENERGIZED, `DMA_SEL_RUN: begin
        // Shown as thousands of hours with two decimals, 65.53 at most
        panel_d.value  = low17(div_pow10({4'h0, mon_sel_q == `DMA_SEL_RUN ? rhours_q : ehours_q}, 3'd1)); // [R21]
        panel_d.dp_pos = 2'd2; // [R20]
      end
      `DMA_SEL_SAVING: begin
        panel_d.value  = {1'b0, mon_in.value}; // [R20]
        panel_d.dp_pos = mon_in.decimals;
      end
      default: begin
        panel_d.value  = {1'b0, mon_in.value};
        panel_d.dp_pos = mon_in.decimals;
        if (trunc_q == `DMA_VAL_ZERO && mon_in.decimals != 2'd0) begin // [R19]
          panel_d.value  = low17(div_pow10({4'h0, mon_in.value}, {1'b0, mon_in.decimals}));
          panel_d.dp_pos = 2'd0;
        end else if (trunc_q == `DMA_VAL_ONE && mon_in.decimals == 2'd2) begin // [R19]
          panel_d.value  = low17(div_pow10({4'h0, mon_in.value}, 3'd1));
          panel_d.dp_pos = 2'd1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      panel_q <= '0;
    end else begin
      panel_q <= panel_d;
    end
  end

  assign panel_out = panel_q;

  // Checks
  logic [2:0] hold_cnt_q;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_cnt_q <= 3'd0;
    end else begin
      hold_cnt_q <= running_in ? 3'd0 : hold_cnt_q + {2'd0, hold_cnt_q != 3'd7};
    end
  end

  term_middle_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R2]
    (mon_sel_q == `DMA_SEL_UNIT_IO && $stable(mon_sel_q)) |=> (panel_out.seg[2][6] && panel_out.terminal_mode))
    else $error("Middle segment dark on unit terminal monitor");

  opt_absent_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R3]
    (mon_sel_q == `DMA_SEL_OPT_IN && !term_in.opt_in_fitted) |=> (panel_out.seg == '0 && panel_out.dp == 4'b0001))
    else $error("Absent option pattern not dark");

  opt_point_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R5]
    (mon_sel_q == `DMA_SEL_OPT_OUT) |=> panel_out.dp == 4'b0010)
    else $error("Second digit point not lit for option outputs");

  energy_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R11]
    (wr_fire && wb_adr_in == `DMA_OFS_ENERGY_CLR && wr_val == `DMA_VAL_ZERO) |=> energy_q == 20'h0_0000)
    else $error("Energy total not cleared by zero write");

  clr_readback_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R12]
    eclr_rd_q == `DMA_VAL_NONE || eclr_rd_q == `DMA_VAL_TEN)
    else $error("Energy clear read-back value illegal");

  energy_clamp_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R10]
    (tick_q && !energy_clr && shift_q != `DMA_VAL_NONE && energy_sum > {1'b0, `DMA_ENERGY_MAX})
    |=> energy_q == `DMA_ENERGY_MAX)
    else $error("Energy total did not clamp");

  ehours_step_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R13]
    tick_q |=> ehours_q == $past(ehours_q) + 16'h0001)
    else $error("Energized hours missed an hourly tick");

  run_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R14]
    (hold_cnt_q == 3'd7 && !run_clr) |=> $stable(rhours_q))
    else $error("Run hours changed while stopped");

  wrap_tally_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R15]
    (tick_q && ehours_q == 16'hFFFF) |=> (ehours_q == 16'h0000 && ewrap_q == $past(ewrap_q) + 16'h0001))
    else $error("Energized wrap tally not bumped");

  run_read_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R18]
    (req && !wb_we_in && !ack_q && wb_adr_in == `DMA_OFS_RUN_CLR) |=> wb_dat_out == 32'h0000_270F)
    else $error("Run clear did not read 9999");

  run_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R16]
    run_clr |=> rhours_q == 16'h0000)
    else $error("Run hours not cleared by zero write");

  tick_single_a: assert property (@(posedge clk_in) disable iff (!arst_n_in) // [R22]
    tick_q |=> !tick_q)
    else $error("Hourly tick longer than one cycle");

endmodule

`default_nettype wire

/* File: include/dma_defs.svh */
`ifndef DMA_DEFS_SVH
`define DMA_DEFS_SVH

// Register byte offsets
`define DMA_OFS_MON_SEL      8'h00
`define DMA_OFS_DIG_SHIFT    8'h04
`define DMA_OFS_TRUNC_SEL    8'h08
`define DMA_OFS_ENERGY_CLR   8'h0C
`define DMA_OFS_RUN_CLR      8'h10
`define DMA_OFS_ENERGY_COMM  8'h14
`define DMA_OFS_ENERGIZED_H  8'h18
`define DMA_OFS_RUN_H        8'h1C
`define DMA_OFS_ENERGIZED_W  8'h20
`define DMA_OFS_RUN_W        8'h24
`define DMA_OFS_ENERGY_RAW   8'h28

// Parameter values
`define DMA_VAL_NONE         16'h270F
`define DMA_VAL_TEN          16'h000A
`define DMA_VAL_ZERO         16'h0000
`define DMA_VAL_ONE          16'h0001
`define DMA_SHIFT_MAX        16'h0004
`define DMA_MON_SEL_RST      7'h00

// Monitor selections
`define DMA_SEL_ENERGIZED    7'h14
`define DMA_SEL_RUN          7'h17
`define DMA_SEL_ENERGY       7'h19
`define DMA_SEL_SAVING       7'h33
`define DMA_SEL_UNIT_IO      7'h37
`define DMA_SEL_OPT_IN       7'h38
`define DMA_SEL_OPT_OUT      7'h39

// Energy limits in 0.01 kWh
`define DMA_ENERGY_MAX       20'hF_423F
`define DMA_DISP_2DEC_LIM    20'h0_2710
`define DMA_DISP_1DEC_LIM    20'h1_86A0

// Hourly time base
`define DMA_HOUR_NS          64'h0000_0346_30B8_A000
`define DMA_CLK_NS           64'h0000_0000_0000_000A
`define DMA_HOUR_CYCLES      (`DMA_HOUR_NS / `DMA_CLK_NS)

`endif

/* File: include/dma_pkg.sv */
`default_nettype none

package dma_pkg;
  typedef logic [6:0] dma_seg_t;
  typedef struct packed {
    logic             terminal_mode;
    logic [16:0]      value;
    logic [1:0]       dp_pos;
    logic             dashes;
    dma_seg_t [3:0]   seg;
    logic [3:0]       dp;
  } dma_panel_s;
  typedef struct packed {
    logic [11:0] unit_in;
    logic [11:0] unit_out;
    logic [23:0] opt_in;
    logic [23:0] opt_out;
    logic        opt_in_fitted;
    logic        opt_out_fitted;
  } dma_term_s;
  typedef struct packed {
    logic [15:0] value;
    logic [1:0]  decimals;
  } dma_mon_s;
endpackage

`default_nettype wire

/* File: dv/dma_panel_model.sv */
`timescale 1ns/10ps
`default_nettype none

module dma_panel_model (
  input  wire dma_pkg::dma_panel_s panel_in,
  input  wire logic                clk_in,
  output var dma_pkg::dma_panel_s  shown_out
);
  // Panel latches one frame a cycle and never answers back, so it cannot stall the block
  always_ff @(posedge clk_in) begin
    shown_out <= panel_in;
  end
endmodule

`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic                clk_in;
  logic                arst_n_in;
  logic                cyc;
  logic                stb;
  logic                we;
  logic                ack;
  logic                running;
  logic [7:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         dwr;
  logic [31:0]         drd;
  logic [31:0]         rv;
  logic [31:0]         h;
  logic [15:0]         power;
  dma_pkg::dma_term_s  term;
  dma_pkg::dma_mon_s   mon;
  dma_pkg::dma_panel_s panel;
  dma_pkg::dma_panel_s shown;
  int                  miscompares = 0;
  int                  n_checks = 0;
  int                  cycles = 0;

  // Hour shortened to 20 cycles so hour counting fits the run
  dma_accum #(.HOUR_CYCLES(64'h0000_0000_0000_0014)) DUT (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dwr), .wb_dat_out(drd), .wb_ack_out(ack),
    .power_in(power), .running_in(running), .term_in(term), .mon_in(mon), .panel_out(panel));

  dma_panel_model panel_model (.panel_in(panel), .clk_in(clk_in), .shown_out(shown));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Classic single cycle; no fixed latency assumed, only a bounded wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dwr <= d;
    sel <= 4'h3;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rv = drd;
    if (ack !== 1'b1) check(32'h0000_0000, 32'h0000_0001, "no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0000_0000);
  endtask

  // Returns a few cycles after an hourly tick, seen as a step of the energized count
  task automatic wait_tick();
    logic [31:0] h0;
    int n;
    rd(8'h18);
    h0 = rv;
    n = 0;
    while (rv === h0 && n < 40) begin
      rd(8'h18);
      n++;
    end
  endtask

  task automatic pchk(input logic [16:0] v, input logic [1:0] d, input string what);
    repeat (3) @(posedge clk_in);
    check({15'h0000, shown.value}, {15'h0000, v}, what);
    check({30'h0000_0000, shown.dp_pos}, {30'h0000_0000, d}, what);
  endtask

  task automatic t_regs();
    rd(8'h04); check(rv, 32'h0000_270F, "shift reset");
    rd(8'h08); check(rv, 32'h0000_270F, "trunc reset");
    rd(8'h0C); check(rv, 32'h0000_270F, "energy clr reset");
    rd(8'h10); check(rv, 32'h0000_270F, "run clr read");
    rd(8'h20); check(rv, 32'h0000_0000, "energized tally");
    rd(8'h24); check(rv, 32'h0000_0000, "run tally");
    wr(8'h40, 32'h0000_1234);
    rd(8'h40); check(rv, 32'h0000_0000, "unmapped");
  endtask

  task automatic t_term();
    wr(8'h00, 32'h0000_0037);
    repeat (3) @(posedge clk_in);
    check({31'h0, shown.terminal_mode}, 32'h0000_0001, "term mode 55");
    check({4'h0, shown.seg}, 32'h0810_2040, "55 all off");
    check({28'h0, shown.dp}, 32'h0000_0000, "55 dp");
    term <= '{unit_in: 12'h001, unit_out: 12'h800, default: 1'b0};
    repeat (3) @(posedge clk_in);
    check({4'h0, shown.seg}, 32'h0A10_2041, "55 lit");
    term <= '0;
    wr(8'h00, 32'h0000_0038);
    repeat (3) @(posedge clk_in);
    check({4'h0, shown.seg}, 32'h0000_0000, "56 absent");
    check({28'h0, shown.dp}, 32'h0000_0001, "56 dp");
    wr(8'h00, 32'h0000_0039);
    repeat (3) @(posedge clk_in);
    check({4'h0, shown.seg}, 32'h0000_0000, "57 absent");
    check({28'h0, shown.dp}, 32'h0000_0002, "57 dp");
    term <= '{opt_out: 24'h00_0001, opt_out_fitted: 1'b1, default: 1'b0};
    repeat (3) @(posedge clk_in);
    check({4'h0, shown.seg}, 32'h0810_2044, "57 fitted lit");
  endtask

  task automatic t_trunc();
    wr(8'h00, 32'h0000_0005);
    mon <= {16'h04D2, 2'h2};
    pchk(17'h0_04D2, 2'h2, "trunc off");
    wr(8'h08, 32'h0000_0000);
    pchk(17'h0_000C, 2'h0, "trunc int");
    mon <= {16'h0063, 2'h2};
    pchk(17'h0_0000, 2'h0, "trunc 0.99");
    wr(8'h08, 32'h0000_0001);
    mon <= {16'h04D2, 2'h2};
    pchk(17'h0_007B, 2'h1, "trunc one dec");
    mon <= {16'h0007, 2'h0};
    pchk(17'h0_0007, 2'h0, "trunc integer");
    wr(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_0033);
    mon <= {16'h04D2, 2'h2};
    pchk(17'h0_04D2, 2'h2, "saving untruncated");
  endtask

  task automatic t_hours();
    wait_tick();
    h = rv;
    wait_tick();
    check(rv, h + 32'h0000_0001, "energized step");
    wr(8'h00, 32'h0000_0014);
    pchk(17'(h + 32'h0000_0001) / 17'h0_000A, 2'h2, "hours panel");
    rd(8'h1C); check(rv, 32'h0000_0000, "run held stopped");
    running <= 1'b1;
    wait_tick();
    rd(8'h1C); check(rv, 32'h0000_0000, "partial hour");
    wait_tick();
    rd(8'h1C); check(rv, 32'h0000_0001, "full hour");
    running <= 1'b0;
    wait_tick();
    rd(8'h1C); check(rv, 32'h0000_0001, "run held");
    wr(8'h10, 32'h0000_270F);
    rd(8'h1C); check(rv, 32'h0000_0001, "9999 no clear");
    wr(8'h10, 32'h0000_0000);
    rd(8'h1C); check(rv, 32'h0000_0000, "run cleared");
    wait_tick();
    h = rv;
    wr(8'h18, 32'h0000_0000);
    rd(8'h18); check(rv, h, "energized no clear");
  endtask

  task automatic t_energy();
    wr(8'h00, 32'h0000_0019);
    power <= 16'h04D2;
    wait_tick();
    wr(8'h0C, 32'h0000_0000);
    rd(8'h28); check(rv, 32'h0000_0000, "energy cleared");
    rd(8'h0C); check(rv, 32'h0000_270F, "clear readback");
    wait_tick();
    rd(8'h28); check(rv, 32'h0000_04D2, "one hour");
    wait_tick();
    rd(8'h28); check(rv, 32'h0000_09A4, "two hours");
    power <= 16'h0000;
    pchk(17'h0_09A4, 2'h2, "0.01 band");
    rd(8'h14); check(rv, 32'h0000_0018, "comm no shift");
    wr(8'h04, 32'h0000_0001);
    rd(8'h14); check(rv, 32'h0000_0002, "comm shift 1");
    pchk(17'h0_00F6, 2'h2, "panel shift 1");
    wr(8'h04, 32'h0000_0000);
    power <= 16'hC350;
    wait_tick();
    wr(8'h0C, 32'h0000_000A);
    rd(8'h0C); check(rv, 32'h0000_000A, "readback 10");
    wr(8'h0C, 32'h0000_0000);
    rd(8'h0C); check(rv, 32'h0000_000A, "never zero");
    wait_tick();
    pchk(17'h0_1388, 2'h1, "0.1 band");
    wait_tick();
    pchk(17'h0_03E8, 2'h0, "1 band");
    power <= 16'hFFFF;
    repeat (15) wait_tick();
    rd(8'h28); check(rv, 32'h000F_423F, "clamped");
    pchk(17'h0_270F, 2'h0, "four digits");
    wr(8'h04, 32'h0000_270F);
    wait_tick();
    rd(8'h28); check(rv, 32'h0000_0000, "wrapped");
  endtask

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("ERROR %0t run did not finish", $time);
      print_verdict();
    end
  end

  initial begin
    arst_n_in = 1'b0;
    {cyc, stb, we, running} = 4'h0;
    adr = 8'h00;
    sel = 4'h0;
    dwr = 32'h0000_0000;
    power = 16'h0000;
    term = '0;
    mon = '0;
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_term();
    t_trunc();
    t_hours();
    t_energy();
    print_verdict();
  end
endmodule

`default_nettype wire
